// ---- hdl/pin_remap_pkg.sv ----
/*
 * Constants for the remappable pin multiplexer: register map, selector
 * codes, peripheral input indices and pad grouping.
 * Assumes a 32-bit APB slave with 12 address bits; pads are numbered
 * group*8 + position, where the position equals the input selector code.
 */
`default_nettype none
package pin_remap_pkg;
    // ========================================================
    // register map
    localparam int ADDR_W = 12;
    localparam logic [11:0] IN_SEL_BASE = 12'h000;
    localparam logic [11:0] OUT_SEL_BASE = 12'h100;
    localparam logic [11:0] IN_LEVEL_ADDR = 12'h200;
    localparam logic [11:0] PAD_LEVEL_ADDR = 12'h204;
    localparam logic [11:0] PAD_OE_ADDR = 12'h208;
    localparam logic [3:0] SEL_RESET = 4'h0;
    localparam int SEL_W = 4;
    localparam int NUM_IN_FUNC = 24;
    localparam int NUM_PADS = 32;
    // ========================================================
    // peripheral input indices (register index = byte offset / 4)
    localparam int FN_EXT_IRQ4 = 0;
    localparam int FN_TMR2_CLK = 1;
    localparam int FN_CAPTURE4 = 2;
    localparam int FN_SPI1_SLAVE_SEL = 3;
    localparam int FN_REFCLK_IN = 4;
    localparam int FN_EXT_IRQ3 = 5;
    localparam int FN_TMR3_CLK = 6;
    localparam int FN_CAPTURE3 = 7;
    localparam int FN_UART1_CTS = 8;
    localparam int FN_UART2_RX = 9;
    localparam int FN_SPI1_DIN = 10;
    localparam int FN_EXT_IRQ2 = 11;
    localparam int FN_TMR4_CLK = 12;
    localparam int FN_CAPTURE1 = 13;
    localparam int FN_CAPTURE5 = 14;
    localparam int FN_UART1_RX = 15;
    localparam int FN_UART2_CTS = 16;
    localparam int FN_SPI2_DIN = 17;
    localparam int FN_FAULT_B = 18;
    localparam int FN_EXT_IRQ1 = 19;
    localparam int FN_TMR5_CLK = 20;
    localparam int FN_CAPTURE2 = 21;
    localparam int FN_SPI2_SLAVE_SEL = 22;
    localparam int FN_FAULT_A = 23;
    // ========================================================
    // input selector codes that name a pad, one mask per group
    localparam logic [7:0] IN_VALID_G0 = 8'hFF;
    localparam logic [7:0] IN_VALID_G1 = 8'hFF;
    localparam logic [7:0] IN_VALID_G2 = 8'hF9;
    localparam logic [7:0] IN_VALID_G3 = 8'hFF;
    // ========================================================
    // output selector codes
    localparam logic [3:0] OUT_NC = 4'h0;
    localparam logic [3:0] OUT_UART1_TX = 4'h1;
    localparam logic [3:0] OUT_UART2_RTS = 4'h2;
    localparam logic [3:0] OUT_SPI1_SS = 4'h3;
    localparam logic [3:0] OUT_COMP2 = 4'h7;
    localparam logic [3:0] OUT_SPI1_DOUT = 4'h3;
    localparam logic [3:0] OUT_SPI2_DOUT = 4'h4;
    localparam logic [3:0] OUT_OCMP = 4'h5;
    localparam logic [3:0] OUT_SPI2_SS = 4'h4;

    function automatic logic [1:0] in_group(input int idx);
        if (idx <= FN_REFCLK_IN) begin
            return 2'h0;
        end else if (idx <= FN_SPI1_DIN) begin
            return 2'h1;
        end else if (idx <= FN_FAULT_B) begin
            return 2'h2;
        end
        return 2'h3;
    endfunction
endpackage
`default_nettype wire

// ---- hdl/peripheral_pin_remap.sv ----
/*
 * Remappable pin multiplexer with its selector registers on APB.
 * Assumes pad inputs and peripheral outputs are synchronous to pclk;
 * every routed signal is registered once on its way through.
 */
// The implementer's own choices: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module peripheral_pin_remap (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [31:0] pad_in,
    output logic [31:0] pad_out,
    output logic [31:0] pad_oe,
    input wire logic uart1_tx,
    input wire logic uart2_rts,
    input wire logic spi1_slave_sel_drv,
    input wire logic comparator2_out,
    input wire logic spi1_dout,
    input wire logic spi2_dout,
    input wire logic out_cmp2,
    input wire logic out_cmp3,
    input wire logic out_cmp4,
    input wire logic spi2_slave_sel_drv,
    output logic ext_irq4,
    output logic tmr2_clk,
    output logic capture4,
    output logic spi1_slave_sel,
    output logic refclk_in,
    output logic ext_irq3,
    output logic tmr3_clk,
    output logic capture3,
    output logic uart1_cts,
    output logic uart2_rx,
    output logic spi1_din,
    output logic ext_irq2,
    output logic tmr4_clk,
    output logic capture1,
    output logic capture5,
    output logic uart1_rx,
    output logic uart2_cts,
    output logic spi2_din,
    output logic fault_b,
    output logic ext_irq1,
    output logic tmr5_clk,
    output logic capture2,
    output logic spi2_slave_sel,
    output logic fault_a
);
    // ========================================================
    // state
    typedef struct packed {
        logic [23:0][3:0] in_sel;
        logic [31:0][3:0] out_sel;
        logic [23:0] fin;
        logic [31:0] pad_out;
        logic [31:0] pad_oe;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } state_type;

    state_type st_r;
    state_type st_nxt;

    logic setup_phase;
    logic write_take;
    logic [4:0] reg_idx;
    logic in_hit;
    logic out_hit;
    logic stat_hit;
    logic [1:0] grp;
    logic [2:0] pos;
    logic [7:0] valid_mask;
    logic [3:0] code;
    logic [31:0] pad_nxt_v;
    logic [31:0] pad_nxt_oe;

    // ========================================================
    // decode
    assign setup_phase = psel && !penable;
    // the write lands only at the completing edge, never in setup
    assign write_take = psel && penable && st_r.pready && pwrite && !st_r.pslverr;
    assign reg_idx = paddr[6:2];
    assign in_hit = (paddr[11:7] == pin_remap_pkg::IN_SEL_BASE[11:7]) && (paddr[1:0] == 2'h0)
                    && (reg_idx < 5'(pin_remap_pkg::NUM_IN_FUNC));
    assign out_hit = (paddr[11:7] == pin_remap_pkg::OUT_SEL_BASE[11:7]) && (paddr[1:0] == 2'h0);
    assign stat_hit = (paddr == pin_remap_pkg::IN_LEVEL_ADDR) || (paddr == pin_remap_pkg::PAD_LEVEL_ADDR)
                      || (paddr == pin_remap_pkg::PAD_OE_ADDR);

    // ========================================================
    // next state
    always_comb begin
        st_nxt = st_r;
        grp = 2'h0;
        pos = 3'h0;
        valid_mask = 8'h00;
        code = 4'h0;
        pad_nxt_v = 32'h0000_0000;
        pad_nxt_oe = 32'h0000_0000;

        // zero wait state: pready rises in the cycle after setup
        st_nxt.pready = setup_phase;
        if (setup_phase) begin
            st_nxt.pslverr = !(in_hit || out_hit || stat_hit);
            st_nxt.prdata = 32'h0000_0000;
            if (!pwrite) begin
                if (in_hit) begin
                    st_nxt.prdata = {28'h0, st_r.in_sel[reg_idx]};
                end else if (out_hit) begin
                    st_nxt.prdata = {28'h0, st_r.out_sel[reg_idx]};
                end else if (paddr == pin_remap_pkg::IN_LEVEL_ADDR) begin
                    st_nxt.prdata = {8'h0, st_r.fin};
                end else if (paddr == pin_remap_pkg::PAD_LEVEL_ADDR) begin
                    st_nxt.prdata = st_r.pad_out;
                end else if (paddr == pin_remap_pkg::PAD_OE_ADDR) begin
                    st_nxt.prdata = st_r.pad_oe;
                end
            end
        end else if (!psel) begin
            st_nxt.pslverr = 1'b0;
        end

        // selectors live in byte lane 0; other lanes have nothing to hold
        if (write_take && pstrb[0]) begin
            if (in_hit) begin
                st_nxt.in_sel[reg_idx] = pwdata[3:0];
            end else if (out_hit) begin
                st_nxt.out_sel[reg_idx] = pwdata[3:0];
            end
        end

        // ====================================================
        // input routing: the code's low bits are the pad position
        for (int i = 0; i < pin_remap_pkg::NUM_IN_FUNC; i++) begin
            grp = pin_remap_pkg::in_group(i);
            code = st_r.in_sel[i];
            pos = code[2:0];
            unique case (grp)
                2'h0: valid_mask = pin_remap_pkg::IN_VALID_G0;
                2'h1: valid_mask = pin_remap_pkg::IN_VALID_G1;
                2'h2: valid_mask = pin_remap_pkg::IN_VALID_G2;
                2'h3: valid_mask = pin_remap_pkg::IN_VALID_G3;
            endcase
            // reserved codes hold the peripheral input low
            if (!code[3] && valid_mask[pos]) begin
                st_nxt.fin[i] = pad_in[{grp, pos}];
            end else begin
                st_nxt.fin[i] = 1'b0;
            end
        end

        // ====================================================
        // output routing
        for (int p = 0; p < pin_remap_pkg::NUM_PADS; p++) begin
            code = st_r.out_sel[p];
            grp = 2'(p / 8);
            unique case (grp)
                2'h0: begin
                    unique case (code)
                        pin_remap_pkg::OUT_UART1_TX: pad_nxt_v[p] = uart1_tx;
                        pin_remap_pkg::OUT_UART2_RTS: pad_nxt_v[p] = uart2_rts;
                        pin_remap_pkg::OUT_SPI1_SS: pad_nxt_v[p] = spi1_slave_sel_drv;
                        pin_remap_pkg::OUT_COMP2: pad_nxt_v[p] = comparator2_out;
                        default: pad_nxt_v[p] = 1'b0;
                    endcase
                    pad_nxt_oe[p] = (code == pin_remap_pkg::OUT_UART1_TX) || (code == pin_remap_pkg::OUT_UART2_RTS)
                                    || (code == pin_remap_pkg::OUT_SPI1_SS) || (code == pin_remap_pkg::OUT_COMP2);
                end
                2'h1, 2'h2: begin
                    unique case (code)
                        pin_remap_pkg::OUT_SPI1_DOUT: pad_nxt_v[p] = spi1_dout;
                        pin_remap_pkg::OUT_SPI2_DOUT: pad_nxt_v[p] = spi2_dout;
                        pin_remap_pkg::OUT_OCMP: pad_nxt_v[p] = (grp == 2'h1) ? out_cmp2 : out_cmp4;
                        default: pad_nxt_v[p] = 1'b0;
                    endcase
                    pad_nxt_oe[p] = (code == pin_remap_pkg::OUT_SPI1_DOUT) || (code == pin_remap_pkg::OUT_SPI2_DOUT)
                                    || (code == pin_remap_pkg::OUT_OCMP);
                end
                2'h3: begin
                    unique case (code)
                        pin_remap_pkg::OUT_SPI2_SS: pad_nxt_v[p] = spi2_slave_sel_drv;
                        pin_remap_pkg::OUT_OCMP: pad_nxt_v[p] = out_cmp3;
                        default: pad_nxt_v[p] = 1'b0;
                    endcase
                    pad_nxt_oe[p] = (code == pin_remap_pkg::OUT_SPI2_SS) || (code == pin_remap_pkg::OUT_OCMP);
                end
            endcase
        end
        // unlisted codes fall to default: released and low, like no-connect
        st_nxt.pad_out = pad_nxt_v;
        st_nxt.pad_oe = pad_nxt_oe;
    end

    // ========================================================
    // registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ========================================================
    // outputs
    assign prdata = st_r.prdata;
    assign pready = st_r.pready;
    assign pslverr = st_r.pslverr;
    assign pad_out = st_r.pad_out;
    assign pad_oe = st_r.pad_oe;
    assign ext_irq4 = st_r.fin[pin_remap_pkg::FN_EXT_IRQ4];
    assign tmr2_clk = st_r.fin[pin_remap_pkg::FN_TMR2_CLK];
    assign capture4 = st_r.fin[pin_remap_pkg::FN_CAPTURE4];
    assign spi1_slave_sel = st_r.fin[pin_remap_pkg::FN_SPI1_SLAVE_SEL];
    assign refclk_in = st_r.fin[pin_remap_pkg::FN_REFCLK_IN];
    assign ext_irq3 = st_r.fin[pin_remap_pkg::FN_EXT_IRQ3];
    assign tmr3_clk = st_r.fin[pin_remap_pkg::FN_TMR3_CLK];
    assign capture3 = st_r.fin[pin_remap_pkg::FN_CAPTURE3];
    assign uart1_cts = st_r.fin[pin_remap_pkg::FN_UART1_CTS];
    assign uart2_rx = st_r.fin[pin_remap_pkg::FN_UART2_RX];
    assign spi1_din = st_r.fin[pin_remap_pkg::FN_SPI1_DIN];
    assign ext_irq2 = st_r.fin[pin_remap_pkg::FN_EXT_IRQ2];
    assign tmr4_clk = st_r.fin[pin_remap_pkg::FN_TMR4_CLK];
    assign capture1 = st_r.fin[pin_remap_pkg::FN_CAPTURE1];
    assign capture5 = st_r.fin[pin_remap_pkg::FN_CAPTURE5];
    assign uart1_rx = st_r.fin[pin_remap_pkg::FN_UART1_RX];
    assign uart2_cts = st_r.fin[pin_remap_pkg::FN_UART2_CTS];
    assign spi2_din = st_r.fin[pin_remap_pkg::FN_SPI2_DIN];
    assign fault_b = st_r.fin[pin_remap_pkg::FN_FAULT_B];
    assign ext_irq1 = st_r.fin[pin_remap_pkg::FN_EXT_IRQ1];
    assign tmr5_clk = st_r.fin[pin_remap_pkg::FN_TMR5_CLK];
    assign capture2 = st_r.fin[pin_remap_pkg::FN_CAPTURE2];
    assign spi2_slave_sel = st_r.fin[pin_remap_pkg::FN_SPI2_SLAVE_SEL];
    assign fault_a = st_r.fin[pin_remap_pkg::FN_FAULT_A];

    // ========================================================
    // checks
    a_g0_low_codes: assert property (
        @(posedge pclk) disable iff (!presetn)
        (st_r.in_sel[0] == 4'h0) |=> (ext_irq4 == $past(pad_in[0]))
    ) else $error("ext_irq4 not routed from pad A0");

    a_g0_code_one: assert property (
        @(posedge pclk) disable iff (!presetn)
        (st_r.in_sel[4] == 4'h1) && $stable(st_r.in_sel[4]) |=> (refclk_in == $past(pad_in[1]))
    ) else $error("refclk_in not routed from pad B3");

    a_g0_mid_codes: assert property (
        @(posedge pclk) disable iff (!presetn)
        (st_r.in_sel[1] >= 4'h2) && (st_r.in_sel[1] <= 4'h7)
        |=> (tmr2_clk == $past(pad_in[st_r.in_sel[1][2:0]]))
    ) else $error("tmr2_clk routed from wrong pad");

    a_g1_route: assert property (
        @(posedge pclk) disable iff (!presetn)
        (st_r.in_sel[9] < 4'h8) |=> (uart2_rx == $past(pad_in[{2'h1, st_r.in_sel[9][2:0]}]))
    ) else $error("uart2_rx routed from wrong pad");

    a_g2_route: assert property (
        @(posedge pclk) disable iff (!presetn)
        ((st_r.in_sel[15] == 4'h0) || ((st_r.in_sel[15] >= 4'h3) && (st_r.in_sel[15] <= 4'h7)))
        |=> (uart1_rx == $past(pad_in[{2'h2, st_r.in_sel[15][2:0]}]))
    ) else $error("uart1_rx routed from wrong pad");

    a_g3_route: assert property (
        @(posedge pclk) disable iff (!presetn)
        (st_r.in_sel[23] < 4'h8) |=> (fault_a == $past(pad_in[{2'h3, st_r.in_sel[23][2:0]}]))
    ) else $error("fault_a routed from wrong pad");

    a_in_reserved_low: assert property (
        @(posedge pclk) disable iff (!presetn)
        (st_r.in_sel[11][3] || (st_r.in_sel[11] == 4'h1) || (st_r.in_sel[11] == 4'h2)) |=> !ext_irq2
    ) else $error("reserved input code did not hold ext_irq2 low");

    a_pad0_uart: assert property (
        @(posedge pclk) disable iff (!presetn)
        (st_r.out_sel[0] == 4'h1) |=> pad_oe[0] && (pad_out[0] == $past(uart1_tx))
    ) else $error("pad A0 does not carry uart1_tx");

    a_pad7_comp: assert property (
        @(posedge pclk) disable iff (!presetn)
        (st_r.out_sel[7] == 4'h7) |=> pad_oe[7] && (pad_out[7] == $past(comparator2_out))
    ) else $error("pad C5 does not carry comparator2_out");

    a_pad8_ocmp: assert property (
        @(posedge pclk) disable iff (!presetn)
        (st_r.out_sel[8] == 4'h5) |=> pad_oe[8] && (pad_out[8] == $past(out_cmp2))
    ) else $error("pad A1 does not carry out_cmp2");

    a_pad16_spi: assert property (
        @(posedge pclk) disable iff (!presetn)
        (st_r.out_sel[16] == 4'h4) |=> pad_oe[16] && (pad_out[16] == $past(spi2_dout))
    ) else $error("pad A2 does not carry spi2_dout");

    a_pad24_ss: assert property (
        @(posedge pclk) disable iff (!presetn)
        (st_r.out_sel[24] == 4'h4) |=> pad_oe[24] && (pad_out[24] == $past(spi2_slave_sel_drv))
    ) else $error("pad A3 does not carry spi2_slave_sel");

    a_out_reserved_nc: assert property (
        @(posedge pclk) disable iff (!presetn)
        (st_r.out_sel[25][3] || (st_r.out_sel[25] == 4'h3) || (st_r.out_sel[25] == 4'h0))
        |=> !pad_oe[25] && !pad_out[25]
    ) else $error("reserved output code drove pad B14");

    a_sel_write_effect: assert property (
        @(posedge pclk) disable iff (!presetn)
        (write_take && pstrb[0] && (paddr == 12'h100)) |=> (st_r.out_sel[0] == $past(pwdata[3:0]))
        ##1 (pad_oe[0] == ($past(pwdata[3:0], 2) inside {4'h1, 4'h2, 4'h3, 4'h7}))
    ) else $error("selector write did not reroute pad A0 one cycle later");

    a_apb_one_wait: assert property (
        @(posedge pclk) disable iff (!presetn)
        setup_phase |=> pready ##1 !pready || setup_phase
    ) else $error("apb access phase not exactly one cycle");

    a_g1_reserved_low: assert property (
        @(posedge pclk) disable iff (!presetn)
        st_r.in_sel[5][3] |=> !ext_irq3
    ) else $error("reserved input code did not hold ext_irq3 low");

    a_g3_irq_route: assert property (
        @(posedge pclk) disable iff (!presetn)
        (st_r.in_sel[19] < 4'h8) |=> (ext_irq1 == $past(pad_in[{2'h3, st_r.in_sel[19][2:0]}]))
    ) else $error("ext_irq1 routed from wrong pad");

    a_pad1_rts: assert property (
        @(posedge pclk) disable iff (!presetn)
        (st_r.out_sel[1] == 4'h2) |=> pad_oe[1] && (pad_out[1] == $past(uart2_rts))
    ) else $error("pad B3 does not carry uart2_rts");

    a_pad9_spi1: assert property (
        @(posedge pclk) disable iff (!presetn)
        (st_r.out_sel[9] == 4'h3) |=> pad_oe[9] && (pad_out[9] == $past(spi1_dout))
    ) else $error("pad B5 does not carry spi1_dout");

    a_pad17_ocmp: assert property (
        @(posedge pclk) disable iff (!presetn)
        (st_r.out_sel[17] == 4'h5) |=> pad_oe[17] && (pad_out[17] == $past(out_cmp4))
    ) else $error("pad B6 does not carry out_cmp4");

    a_pad26_ocmp: assert property (
        @(posedge pclk) disable iff (!presetn)
        (st_r.out_sel[26] == 4'h5) |=> pad_oe[26] && (pad_out[26] == $past(out_cmp3))
    ) else $error("pad B0 does not carry out_cmp3");

    a_pad18_reserved: assert property (
        @(posedge pclk) disable iff (!presetn)
        ((st_r.out_sel[18] == 4'h1) || (st_r.out_sel[18] == 4'h2)) |=> !pad_oe[18] && !pad_out[18]
    ) else $error("reserved output code drove pad A4");

    a_in_sel_write: assert property (
        @(posedge pclk) disable iff (!presetn)
        (write_take && pstrb[0] && (paddr == 12'h000)) |=> (st_r.in_sel[0] == $past(pwdata[3:0]))
    ) else $error("input selector write did not land");
endmodule
`default_nettype wire

// ---- verif/pad_partner.sv ----
/*
 * Far-side model of the pin multiplexer: package pads and the peripheral
 * outputs that can be routed to pads.
 * Assumes the bench commands pad and peripheral levels; they change only
 * after a rising pclk edge, as real synchronous logic would.
 */
`timescale 1ns/1ps
`default_nettype none
module pad_partner (
    input wire logic pclk,
    input wire logic [31:0] pad_level,
    input wire logic [9:0] per_level,
    input wire logic [31:0] pad_out,
    input wire logic [31:0] pad_oe,
    output logic [31:0] pad_in,
    output logic [9:0] per_out
);
    logic [31:0] ext_r;
    // ========================================================
    // pad wire: a pad that the block drives shows the block's level
    always_ff @(posedge pclk) begin
        ext_r <= pad_level;
        per_out <= per_level;
    end
    assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_r);
endmodule
`default_nettype wire

// ---- verif/tb.sv ----
/*
 * Self-checking bench for the remappable pin multiplexer.
 * Assumes the APB slave answers in one access cycle and that routed
 * signals appear within a few cycles of a selector or level change.
 */
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000, pad_level = 32'h0000_0000, rd;
    logic [3:0] pstrb = 4'hF;
    logic [9:0] per_level = 10'h000, per;
    logic [31:0] prdata, pad_in, pad_out, pad_oe;
    logic pready, pslverr, err;
    logic ext_irq4, tmr2_clk, capture4, spi1_slave_sel, refclk_in, ext_irq3, tmr3_clk, capture3;
    logic uart1_cts, uart2_rx, spi1_din, ext_irq2, tmr4_clk, capture1, capture5, uart1_rx;
    logic uart2_cts, spi2_din, fault_b, ext_irq1, tmr5_clk, capture2, spi2_slave_sel, fault_a;
    logic [23:0] fn_out;
    int errors = 0, comparisons = 0, cycles = 0;
    assign fn_out = {fault_a, spi2_slave_sel, capture2, tmr5_clk, ext_irq1, fault_b, spi2_din, uart2_cts,
        uart1_rx, capture5, capture1, tmr4_clk, ext_irq2, spi1_din, uart2_rx, uart1_cts, capture3,
        tmr3_clk, ext_irq3, refclk_in, spi1_slave_sel, capture4, tmr2_clk, ext_irq4};
    always #2.5 pclk = ~pclk;
    peripheral_pin_remap peripheral_pin_remap_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .pad_in(pad_in), .pad_out(pad_out),
        .pad_oe(pad_oe), .uart1_tx(per[0]), .uart2_rts(per[1]), .spi1_slave_sel_drv(per[2]),
        .comparator2_out(per[3]), .spi1_dout(per[4]), .spi2_dout(per[5]), .out_cmp2(per[6]),
        .out_cmp3(per[7]), .out_cmp4(per[8]), .spi2_slave_sel_drv(per[9]), .ext_irq4(ext_irq4), .tmr2_clk(tmr2_clk),
        .capture4(capture4), .spi1_slave_sel(spi1_slave_sel), .refclk_in(refclk_in),
        .ext_irq3(ext_irq3), .tmr3_clk(tmr3_clk), .capture3(capture3), .uart1_cts(uart1_cts),
        .uart2_rx(uart2_rx), .spi1_din(spi1_din), .ext_irq2(ext_irq2), .tmr4_clk(tmr4_clk),
        .capture1(capture1), .capture5(capture5), .uart1_rx(uart1_rx), .uart2_cts(uart2_cts),
        .spi2_din(spi2_din), .fault_b(fault_b), .ext_irq1(ext_irq1), .tmr5_clk(tmr5_clk),
        .capture2(capture2), .spi2_slave_sel(spi2_slave_sel), .fault_a(fault_a));
    pad_partner pad_partner_inst (.pclk(pclk), .pad_level(pad_level), .per_level(per_level),
        .pad_out(pad_out), .pad_oe(pad_oe), .pad_in(pad_in), .per_out(per));
    // ========================================================
    // verdict and hang guard
    task automatic give_verdict();
        if (errors == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    always @(posedge pclk) begin
        cycles++;
        if (cycles >= 40000) begin
            errors++;
            give_verdict();
        end
    end
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // ========================================================
    // apb master: holds the request until pready is sampled high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic settle();
        repeat (4) @(posedge pclk);
    endtask
    // ========================================================
    // reference routing tables
    function automatic logic exp_in(input int i, input int c, input logic [31:0] pads);
        int g;
        g = (i <= 4) ? 0 : (i <= 10) ? 1 : (i <= 18) ? 2 : 3;
        if (c > 7 || (g == 2 && (c == 1 || c == 2))) begin
            return 1'b0;
        end
        return pads[g*8+c];
    endfunction
    // -1 not driven, otherwise the bench's peripheral bit
    function automatic int exp_src(input int g, input int c);
        case (g)
            0: return (c == 1) ? 0 : (c == 2) ? 1 : (c == 3) ? 2 : (c == 7) ? 3 : -1;
            1: return (c == 3) ? 4 : (c == 4) ? 5 : (c == 5) ? 6 : -1;
            2: return (c == 3) ? 4 : (c == 4) ? 5 : (c == 5) ? 8 : -1;
            default: return (c == 4) ? 9 : (c == 5) ? 7 : -1;
        endcase
    endfunction
    // ========================================================
    // scenarios
    task automatic reset_values();
        for (int a = 0; a < 64; a++) begin
            apb(1'b0, 12'(a < 24 ? 4 * a : 12'h100 + 4 * (a - 24)), 32'h0, 4'hF);
            check("selector reset", a < 56 ? rd : {31'h0, ~err}, 32'h0);
        end
        apb(1'b0, 12'h300, 32'h0, 4'hF);
        check("unmapped error", {31'h0, err}, 32'h1);
        apb(1'b0, 12'h002, 32'h0, 4'hF);
        check("misaligned error", {31'h0, err}, 32'h1);
        apb(1'b1, 12'h004, 32'hFFFF_FFF5, 4'hF);
        apb(1'b0, 12'h004, 32'h0, 4'hF);
        check("selector width", rd, 32'h5);
        apb(1'b1, 12'h004, 32'h3, 4'h0);
        apb(1'b0, 12'h004, 32'h0, 4'hF);
        check("strobe ignored", rd, 32'h5);
        apb(1'b1, 12'h004, 32'h0, 4'hF);
    endtask
    task automatic input_routing();
        logic e;
        for (int i = 0; i < 24; i++) begin
            for (int c = 0; c < 16; c++) begin
                apb(1'b1, 12'(4 * i), 32'(c), 4'hF);
                for (int k = 0; k < 2; k++) begin
                    pad_level <= (c < 8) ? (k ? ~(32'h1 << ((i <= 4 ? 0 : i <= 10 ? 8 : i <= 18 ? 16 : 24) + c))
                        : (32'h1 << ((i <= 4 ? 0 : i <= 10 ? 8 : i <= 18 ? 16 : 24) + c))) : 32'hFFFF_FFFF;
                    settle();
                    e = exp_in(i, c, pad_level);
                    check("input route", {31'h0, fn_out[i]}, {31'h0, e});
                end
            end
            apb(1'b1, 12'(4 * i), 32'h0, 4'hF);
        end
        pad_level <= 32'h0;
    endtask
    task automatic output_routing();
        int s;
        for (int p = 0; p < 32; p++) begin
            for (int c = 0; c < 16; c++) begin
                s = exp_src(p / 8, c);
                apb(1'b1, 12'(12'h100 + 4 * p), 32'(c), 4'hF);
                for (int k = 0; k < 2; k++) begin
                    per_level <= (s >= 0) ? (k ? ~(10'h1 << s) : (10'h1 << s)) : 10'h3FF;
                    settle();
                    check("pad enable", {31'h0, pad_oe[p]}, {31'h0, s != -1});
                    check("pad level", {31'h0, pad_out[p]}, {31'h0, s >= 0 && k == 0});
                end
            end
            apb(1'b1, 12'(12'h100 + 4 * p), 32'h0, 4'hF);
        end
    endtask
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        reset_values();
        input_routing();
        output_routing();
        give_verdict();
    end
endmodule
`default_nettype wire
